//--- core/cad_pkg.sv
package cad_pkg;

  localparam int unsigned PROG_AW = 16;
  localparam int unsigned WORD_W  = 16;
  localparam int unsigned DATA_W  = 8;

  localparam logic [7:0] ADDR_PCL    = 8'h02;
  localparam logic [7:0] ADDR_PCLATH = 8'h03;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_ACC    = 8'h0A;
  localparam logic [7:0] ADDR_PRODL  = 8'h18;
  localparam logic [7:0] ADDR_PRODH  = 8'h19;
  localparam logic [7:0] ADDR_MODE   = 8'h1A;

  localparam int unsigned FLAG_C  = 0;
  localparam int unsigned FLAG_NIBBLE = 1;
  localparam int unsigned FLAG_Z      = 2;
  localparam int unsigned FLAG_SIGN   = 3;
  localparam int unsigned MODE_LO = 0;
  localparam int unsigned MODE_HI = 1;

  localparam logic [15:0] PC_RST         = 16'h0000;
  localparam logic [15:0] WORD_RST       = 16'h0000;
  localparam logic [7:0]  STATUS_RST     = 8'hF0;
  localparam logic [7:0]  BYTE_RST       = 8'h00;
  localparam logic [15:0] INT_PROG_LIMIT = 16'h1000;

  typedef enum logic [1:0] {
    MODE_MCU  = 2'h0,
    MODE_PMCU = 2'h1,
    MODE_MPU  = 2'h2,
    MODE_EXT  = 2'h3
  } cad_mode_type;

  localparam cad_mode_type MODE_RST = MODE_MCU;

  typedef enum logic [3:0] {
    OP_ADD  = 4'h0,
    OP_ADDC = 4'h1,
    OP_SUB  = 4'h2,
    OP_SUBB = 4'h3,
    OP_AND  = 4'h4,
    OP_IOR  = 4'h5,
    OP_XOR  = 4'h6,
    OP_COMF = 4'h7,
    OP_RLC  = 4'h8,
    OP_RRC  = 4'h9,
    OP_RLN  = 4'hA,
    OP_RRN  = 4'hB,
    OP_MOVE = 4'hC,
    OP_CLR  = 4'hD,
    OP_MUL  = 4'hE,
    OP_SWAP = 4'hF
  } cad_op_type;

endpackage

//--- core/cad_multiplier.sv
`timescale 1ns/100ps
module cad_multiplier (
  input  wire logic [7:0]  multA,
  input  wire logic [7:0]  multB,
  output logic      [15:0] product
);

  // shift-add array, settles within one cycle
  always_comb begin
    product = 16'h0000;
    for (int i = 0; i < 8; i++) begin
      if (multB[i]) begin
        product = product + ({8'h00, multA} << i);
      end
    end
  end

endmodule

//--- core/cad_datapath.sv
`timescale 1ns/100ps
module cad_datapath #(
  parameter logic MULT_FITTED = 1'b1
) (
  input  wire logic                         clock,
  input  wire logic                         sys_rst,
  output logic      [cad_pkg::PROG_AW-1:0]  progAddr,
  input  wire logic [cad_pkg::WORD_W-1:0]   progData,
  output logic                              progExternal,
  output logic                              codeProtect,
  output logic      [cad_pkg::WORD_W-1:0]   instrWord,
  output logic                              instrValid,
  input  wire logic                         branchTake,
  input  wire logic [cad_pkg::PROG_AW-1:0]  branchTarget,
  input  wire logic                         stallReq,
  input  wire logic                         exeValid,
  input  wire cad_pkg::cad_op_type          exeOp,
  input  wire logic                         exeToFile,
  input  wire logic [cad_pkg::DATA_W-1:0]   fileData,
  output logic      [cad_pkg::DATA_W-1:0]   fileWrData,
  output logic                              fileWrite,
  input  wire logic [7:0]                   regAddr,
  input  wire logic [cad_pkg::DATA_W-1:0]   regWrData,
  input  wire logic                         regWrite,
  input  wire logic                         regRead,
  output logic      [cad_pkg::DATA_W-1:0]   regRdData
);
  import cad_pkg::*;

  // add, subtract, shift, logic
  // {sign, zero, nibble, carry, result}
  function automatic logic [11:0] aluCalc(
    input cad_op_type op,
    input logic [7:0] f,
    input logic [7:0] w,
    input logic       cin
  );
    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] b;
    logic [7:0] res;
    logic       ci;
    logic       c;
    logic       hc;
    logic       sc;
    sum = 9'h000;
    nib = 5'h00;
    b   = w;
    res = 8'h00;
    ci  = 1'b0;
    c   = cin;
    hc  = 1'b0;
    sc  = 1'b0;
    case (op)
      OP_ADD, OP_ADDC, OP_SUB, OP_SUBB: begin
        // subtract as f + ~w + 1, so carry reads as not-borrow
        b   = (op == OP_SUB || op == OP_SUBB) ? ~w : w;
        ci  = (op == OP_SUB) ? 1'b1 : ((op == OP_ADD) ? 1'b0 : cin);
        nib = {1'b0, f[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        sum = {1'b0, f} + {1'b0, b} + {8'h00, ci};
        res = sum[7:0];
        c   = sum[8];
        hc  = nib[4];
        sc  = sum[8] ^ (f[7] ^ b[7] ^ sum[7]);
      end
      OP_AND:  res = f & w;
      OP_IOR:  res = f | w;
      OP_XOR:  res = f ^ w;
      OP_COMF: res = ~f;
      OP_RLC: begin
        res = {f[6:0], cin};
        c   = f[7];
      end
      OP_RRC: begin
        res = {cin, f[7:1]};
        c   = f[0];
      end
      OP_RLN:  res = {f[6:0], f[7]};
      OP_RRN:  res = {f[0], f[7:1]};
      OP_MOVE: res = f;
      OP_SWAP: res = {f[3:0], f[7:4]};
      default: res = 8'h00;
    endcase
    return {sc, (res == 8'h00), hc, c, res};
  endfunction

  // which of {sign, zero, nibble, carry} an operation writes
  function automatic logic [3:0] flagMask(input cad_op_type op);
    case (op)
      OP_ADD, OP_ADDC, OP_SUB, OP_SUBB:         return 4'hF;
      OP_AND, OP_IOR, OP_XOR, OP_COMF, OP_CLR: return 4'h4;
      OP_RLC, OP_RRC:                          return 4'h1;
      default:                                 return 4'h0;
    endcase
  endfunction

  function automatic logic fetchExt(input cad_mode_type m, input logic [15:0] a);
    case (m)
      MODE_MPU: return 1'b1;
      MODE_EXT: return (a >= INT_PROG_LIMIT);
      default:  return 1'b0;
    endcase
  endfunction

  logic [15:0]  nextPc;
  logic         pclWrite;
  logic [7:0]   pclath;
  logic [7:0]   acc;
  logic [7:0]   status;
  logic [7:0]   prodLo;
  logic [7:0]   prodHi;
  cad_mode_type modeSel;
  logic [11:0]  aluOut;
  logic [7:0]   aluRes;
  logic [3:0]   aluMask;
  logic [15:0]  multProduct;
  logic         multDo;
  logic         accAluWr;
  logic         fileA7;
  logic         accW7;

  assign pclWrite = regWrite && (regAddr == ADDR_PCL);
  assign aluOut   = aluCalc(exeOp, fileData, acc, status[FLAG_C]);
  assign aluRes   = aluOut[7:0];
  assign aluMask  = exeValid ? flagMask(exeOp) : 4'h0;
  assign multDo   = exeValid && (exeOp == OP_MUL) && MULT_FITTED;
  assign accAluWr = exeValid && !exeToFile && (exeOp != OP_MUL);
  assign fileA7   = fileData[7];
  assign accW7    = acc[7];

  cad_multiplier u_mult (
    .multA   (fileData),
    .multB   (acc),
    .product (multProduct)
  );

  always_comb begin
    nextPc = progAddr + 16'h0001;
    if (branchTake) begin
      nextPc = branchTarget;
    end else if (pclWrite) begin
      nextPc = {pclath, regWrData};
    end else if (stallReq) begin
      nextPc = progAddr;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      progAddr   <= PC_RST;
      instrWord  <= WORD_RST;
      instrValid <= 1'b0;
    end else begin
      progAddr <= nextPc;
      if (branchTake || pclWrite || stallReq) begin
        instrValid <= 1'b0;
      end else begin
        instrWord  <= progData;
        instrValid <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      progExternal <= 1'b0;
      codeProtect  <= 1'b0;
    end else begin
      progExternal <= fetchExt(modeSel, nextPc);
      codeProtect  <= (modeSel == MODE_PMCU);
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      modeSel <= MODE_RST;
    end else if (regWrite && regAddr == ADDR_MODE) begin
      modeSel <= cad_mode_type'(regWrData[MODE_HI:MODE_LO]);
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pclath <= BYTE_RST;
    end else if (regWrite && regAddr == ADDR_PCLATH) begin
      pclath <= regWrData;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      acc <= BYTE_RST;
    end else if (accAluWr) begin
      acc <= aluRes;
    end else if (regWrite && regAddr == ADDR_ACC) begin
      acc <= regWrData;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      fileWrData <= BYTE_RST;
      fileWrite  <= 1'b0;
    end else begin
      fileWrite <= exeValid && exeToFile && (exeOp != OP_MUL);
      if (exeValid) begin
        fileWrData <= aluRes;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      status <= STATUS_RST;
    end else begin
      // flag bits: execute wins over a same-cycle bus write
      for (int i = 0; i < 4; i++) begin
        if (aluMask[i]) begin
          status[i] <= aluOut[8+i];
        end else if (regWrite && regAddr == ADDR_STATUS) begin
          status[i] <= regWrData[i];
        end
      end
      if (regWrite && regAddr == ADDR_STATUS) begin
        status[7:4] <= regWrData[7:4];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      prodLo <= BYTE_RST;
      prodHi <= BYTE_RST;
    end else if (multDo) begin
      prodLo <= multProduct[7:0];
      prodHi <= multProduct[15:8];
    end else begin
      if (regWrite && regAddr == ADDR_PRODL) begin
        prodLo <= regWrData;
      end
      if (regWrite && regAddr == ADDR_PRODH) begin
        prodHi <= regWrData;
      end
    end
  end

  // core registers readable in data space
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      regRdData <= BYTE_RST;
    end else if (regRead) begin
      case (regAddr)
        ADDR_PCL:    regRdData <= progAddr[7:0];
        ADDR_PCLATH: regRdData <= pclath;
        ADDR_STATUS: regRdData <= status;
        ADDR_ACC:    regRdData <= acc;
        ADDR_PRODL:  regRdData <= prodLo;
        ADDR_PRODH:  regRdData <= prodHi;
        ADDR_MODE:   regRdData <= {6'h00, modeSel};
        default:     regRdData <= BYTE_RST;
      endcase
    end else begin
      regRdData <= BYTE_RST;
    end
  end

  a_fetch_advance: assert property (
    @(posedge clock) disable iff (sys_rst)
    (!sys_rst && !branchTake && !pclWrite && !stallReq)
      |=> (progAddr == $past(progAddr) + 16'h0001) && instrValid
          && (instrWord == $past(progData))
  ) else $error("fetch did not advance by one word");

  a_branch_bubble: assert property (
    @(posedge clock) disable iff (sys_rst)
    branchTake |=> !instrValid && (progAddr == $past(branchTarget))
  ) else $error("branch did not insert a bubble");

  a_stall_hold: assert property (
    @(posedge clock) disable iff (sys_rst)
    (stallReq && !branchTake && !pclWrite)
      |=> !instrValid && $stable(progAddr) && $stable(instrWord)
  ) else $error("stall did not hold the fetch");

  a_ext_no_protect: assert property (
    @(posedge clock) disable iff (sys_rst)
    (modeSel == MODE_EXT) |=> !codeProtect
  ) else $error("protection active in extended mode");

  a_mpu_fetch_ext: assert property (
    @(posedge clock) disable iff (sys_rst)
    (modeSel == MODE_MPU) |=> progExternal
  ) else $error("external-only mode fetched internally");

  a_read_word: assert property (
    @(posedge clock) disable iff (sys_rst)
    (regRead && regAddr == ADDR_ACC) |=> (regRdData == $past(acc))
  ) else $error("accumulator read back wrong");

  a_move_keeps_w: assert property (
    @(posedge clock) disable iff (sys_rst)
    (exeValid && exeToFile && !(regWrite && regAddr == ADDR_ACC))
      |=> $stable(acc) && (fileWrite == ($past(exeOp) != OP_MUL))
  ) else $error("file destination disturbed accumulator");

  a_logic_and: assert property (
    @(posedge clock) disable iff (sys_rst)
    (exeValid && exeOp == OP_AND)
      |=> (fileWrData == ($past(fileData) & $past(acc)))
  ) else $error("logical and result wrong");

  a_add_unsigned: assert property (
    @(posedge clock) disable iff (sys_rst)
    (exeValid && exeOp == OP_ADD)
      |=> ({status[FLAG_C], fileWrData} == 9'($past(fileData)) + 9'($past(acc)))
  ) else $error("unsigned add wrong");

  a_acc_alu: assert property (
    @(posedge clock) disable iff (sys_rst)
    accAluWr |=> (acc == $past(aluRes))
  ) else $error("accumulator missed alu result");

  a_zero_flag: assert property (
    @(posedge clock) disable iff (sys_rst)
    aluMask[FLAG_Z] |=> (status[FLAG_Z] == (fileWrData == 8'h00))
  ) else $error("zero flag wrong");

  a_sub_borrow: assert property (
    @(posedge clock) disable iff (sys_rst)
    (exeValid && exeOp == OP_SUB)
      |=> (status[FLAG_C] == ($past(fileData) >= $past(acc)))
  ) else $error("subtract borrow wrong");

  a_sign_change: assert property (
    @(posedge clock) disable iff (sys_rst)
    (exeValid && exeOp == OP_ADD)
      |=> (status[FLAG_SIGN] ==
           (status[FLAG_C] ^ $past(fileA7) ^ $past(accW7) ^ fileWrData[7]))
  ) else $error("sign change flag wrong");

  a_flags_kept: assert property (
    @(posedge clock) disable iff (sys_rst)
    (exeValid && exeOp == OP_MOVE && !regWrite) |=> $stable(status)
  ) else $error("move changed status flags");

  a_product: assert property (
    @(posedge clock) disable iff (sys_rst)
    multDo |=> ({prodHi, prodLo} == 16'($past(fileData)) * 16'($past(acc)))
  ) else $error("product wrong");

endmodule

//--- verif/cad_prog_mem_model.sv
`timescale 1ns/100ps
module cad_prog_mem_model #(
  parameter logic [15:0] PATTERN = 16'hA5C3
) (
  input  wire logic [15:0] progAddr,
  output logic      [15:0] progData
);
  // whole word per address
  // every one of the 64K addresses answers with its own word
  assign progData = progAddr ^ PATTERN;
endmodule

//--- verif/cad_datapath_tb.sv
`timescale 1ns/100ps
module cad_datapath_tb;
  import cad_pkg::*;
  localparam logic [15:0] PAT = 16'hA5C3;
  logic             clock = 1'b0;
  logic             sys_rst = 1'b1;
  logic [15:0]      progAddr, progData, instrWord, branchTarget = 16'h0000;
  logic             progExternal, codeProtect, instrValid, fileWrite;
  logic             branchTake = 1'b0, stallReq = 1'b0, exeValid = 1'b0, exeToFile = 1'b0;
  cad_op_type       exeOp = OP_ADD;
  logic [7:0]       fileData = 8'h00, fileWrData, regRdData, regAddr = 8'h00;
  logic [7:0]       regWrData = 8'h00;
  logic             regWrite = 1'b0, regRead = 1'b0, rdSeen = 1'b0;
  logic [15:0]      prevAddr = 16'h0000, p;
  logic [7:0]       rq[$], fq[$], w, f, s, r;
  int               bad_count = 0, n_compared = 0;
  cad_op_type       op;

  cad_datapath #(.MULT_FITTED(1'b1)) DUT (.clock(clock), .sys_rst(sys_rst),
    .progAddr(progAddr), .progData(progData), .progExternal(progExternal),
    .codeProtect(codeProtect), .instrWord(instrWord), .instrValid(instrValid),
    .branchTake(branchTake), .branchTarget(branchTarget), .stallReq(stallReq),
    .exeValid(exeValid), .exeOp(exeOp), .exeToFile(exeToFile), .fileData(fileData),
    .fileWrData(fileWrData), .fileWrite(fileWrite), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData));
  cad_prog_mem_model #(.PATTERN(PAT)) partner (.progAddr(progAddr), .progData(progData));

  always #5 clock = ~clock;

  task automatic chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask

  task automatic give_verdict();
    $display("compared %0d, mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr   <= a;
    regWrData <= d;
    regWrite  <= 1'b1;
    @(posedge clock);
    regWrite  <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    rq.push_back(e);
    @(posedge clock);
    regRead <= 1'b0;
  endtask

  task automatic exe(input cad_op_type o, input logic [7:0] d, input logic tf);
    @(posedge clock);
    exeValid  <= 1'b1;
    exeOp     <= o;
    fileData  <= d;
    exeToFile <= tf;
    @(posedge clock);
    exeValid  <= 1'b0;
  endtask

  task automatic branch(input logic [15:0] t);
    @(posedge clock);
    branchTake   <= 1'b1;
    branchTarget <= t;
    @(posedge clock);
    branchTake   <= 1'b0;
    #1 chk(progAddr === t && instrValid === 1'b0, "branch target");
  endtask

  // expected status in the upper byte, result in the lower
  function automatic logic [15:0] alu(cad_op_type o, logic [7:0] a, logic [7:0] b,
                                      logic [7:0] st);
    logic [8:0] t;
    logic [4:0] h;
    logic [7:0] l, x, res;
    logic       c, ci;
    c   = st[FLAG_C];
    res = a;
    x   = (o == OP_SUB || o == OP_SUBB) ? ~b : b;
    ci  = (o == OP_ADD) ? 1'b0 : (o == OP_SUB) ? 1'b1 : c;
    case (o)
      OP_ADD, OP_ADDC, OP_SUB, OP_SUBB: begin
        t = a + x + ci;
        h = a[3:0] + x[3:0] + ci;
        l = a[6:0] + x[6:0] + ci;
        res = t[7:0];
        st[FLAG_C]  = t[8];
        st[FLAG_NIBBLE] = h[4];
        st[FLAG_SIGN]   = l[7] ^ t[8];
      end
      OP_AND:  res = a & b;
      OP_IOR:  res = a | b;
      OP_XOR:  res = a ^ b;
      OP_COMF: res = ~a;
      OP_CLR:  res = 8'h00;
      OP_SWAP: res = {a[3:0], a[7:4]};
      OP_RLN:  res = {a[6:0], a[7]};
      OP_RRN:  res = {a[0], a[7:1]};
      OP_RLC: begin
        res = {a[6:0], c};
        st[FLAG_C] = a[7];
      end
      OP_RRC: begin
        res = {c, a[7:1]};
        st[FLAG_C] = a[0];
      end
      default: res = a;
    endcase
    if (o inside {OP_ADD, OP_ADDC, OP_SUB, OP_SUBB, OP_AND, OP_IOR, OP_XOR, OP_COMF, OP_CLR})
      st[FLAG_Z] = (res == 8'h00);
    return {st, res};
  endfunction

  // watcher: takes the oldest note whenever a result shows
  always @(posedge clock) begin
    if (!sys_rst) begin
      if (rdSeen) chk(rq.size() > 0 && regRdData === rq.pop_front(), "read data");
      if (fileWrite !== 1'b0)
        chk(fq.size() > 0 && fileWrData === fq.pop_front(), "file result");
      if (instrValid === 1'b1) chk(instrWord === (prevAddr ^ PAT), "fetched word");
    end
    rdSeen   = regRead & ~sys_rst;
    prevAddr = progAddr;
  end

  initial begin
    repeat (20000) @(posedge clock);
    chk(1'b0, "run too long");
    give_verdict();
  end

  initial begin
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    void'($urandom(32'h2d6d));
    rd(ADDR_STATUS, STATUS_RST);
    rd(ADDR_ACC, BYTE_RST);
    rd(ADDR_MODE, BYTE_RST);
    rd(8'h7F, 8'h00);
    for (int i = 0; i < 48; i++) begin
      op = cad_op_type'(i % 16);
      if (op == OP_MUL) continue;
      w = $urandom;
      f = $urandom;
      s = $urandom;
      wr(ADDR_ACC, w);
      wr(ADDR_STATUS, s);
      {s, r} = alu(op, f, w, s);
      if (i / 16 != 1) fq.push_back(r);
      else w = r;
      exe(op, f, i / 16 != 1);
      rd(ADDR_STATUS, s);
      rd(ADDR_ACC, w);
    end
    w = $urandom;
    f = $urandom;
    p = {8'h00, f} * {8'h00, w};
    wr(ADDR_ACC, w);
    exe(OP_MUL, f, 1'b0);
    rd(ADDR_PRODL, p[7:0]);
    rd(ADDR_PRODH, p[15:8]);
    for (int i = 0; i < 4; i++) branch(16'($urandom));
    @(posedge clock);
    stallReq <= 1'b1;
    #1 p = progAddr;
    @(posedge clock);
    stallReq <= 1'b0;
    #1 chk(progAddr === p && instrValid === 1'b0, "stall hold");
    wr(ADDR_PCLATH, 8'h12);
    wr(ADDR_PCL, 8'h34);
    #1 chk(progAddr === 16'h1234 && instrValid === 1'b0, "pc write");
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_MODE, 8'(m));
      rd(ADDR_MODE, 8'(m));
      if (m == 3) branch(INT_PROG_LIMIT);
      else repeat (2) @(posedge clock);
      #1 chk(codeProtect === (m == 1), "protection by mode");
      chk(progExternal === (m >= 2), "external fetch");
    end
    branch(16'h0010);
    #1 chk(progExternal === 1'b0, "internal below limit");
    repeat (3) @(posedge clock);
    chk(rq.size() == 0 && fq.size() == 0, "results missing");
    give_verdict();
  end
endmodule
